// >>> shared/apo_pkg.sv
// Package for the analog power override register bank.
// Assumes an 8-bit register address space reached through the host control port.
package apo_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] OVR_A_ADDR = 8'h22;
  localparam logic [7:0] OVR_B_ADDR = 8'h23;
  localparam logic [7:0] STATE_A_ADDR = 8'h24;
  localparam logic [7:0] STATE_B_ADDR = 8'h25;
  localparam logic [7:0] R_OVR_A_ADDR = 8'h26;
  localparam logic [7:0] OVR_A_RST = 8'h00;
  localparam logic [7:0] OVR_B_RST = 8'h00;
  localparam logic [7:0] STATE_A_RST = 8'h00;
  localparam logic [7:0] STATE_B_RST = 8'h00;
  localparam logic [7:0] R_OVR_A_RST = 8'h00;
  // Group A field positions (same for override and state registers)
  localparam int unsigned A_BIAS_REF_BIT = 5;
  localparam int unsigned A_DAC_BIT = 4;
  localparam int unsigned A_DRIVER_BIT = 3;
  localparam int unsigned A_DRIVER_BIAS_BIT = 2;
  localparam int unsigned A_CMFB_BIT = 1;
  localparam int unsigned A_OUTSTAGE_BIT = 0;
  // Group B field positions
  localparam int unsigned B_GAINCTL_BIT = 7;
  localparam int unsigned B_ANALOG_SILENCE_BIT = 6;
  localparam int unsigned B_ANALOG_SILENCE_DUMMY_BIT = 5;
  localparam int unsigned B_CHARGE_PUMP_BIT = 4;
  localparam int unsigned B_OFFCAL_BIT = 3;
  localparam int unsigned B_SHORTPROT_BIT = 2;
  localparam int unsigned B_IMPSENSE_BIT = 1;
  localparam int unsigned B_IMPWHOLE_BIT = 0;
  localparam logic [7:0] A_FUNC_MASK = 8'h3f;
  localparam logic [7:0] R_FUNC_MASK = 8'h1f;
endpackage

// >>> design/apo_pwr_mux.sv
// Per-bit power enable select between sequencer and forced state.
// Assumes all inputs are in the ref_clk domain.
`timescale 1ns/1ns
module apo_pwr_mux #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] force_en,
  input wire logic [WIDTH-1:0] forced_on,
  input wire logic [WIDTH-1:0] seq_on,
  output logic [WIDTH-1:0] pwr_on
);
  // Refused at elaboration, not at run time
  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("apo_pwr_mux: WIDTH must be at least 1");
    end
  endgenerate

  logic [WIDTH-1:0] pwr_d;
  logic [WIDTH-1:0] pwr_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_comb
      begin
        pwr_d[i] = force_en[i] ? forced_on[i] : seq_on[i];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pwr_q <= '0;
    end
    else
    begin
      pwr_q <= pwr_d;
    end
  end

  assign pwr_on = pwr_q;
endmodule

// >>> design/apo_regs.sv
// Analog power override register bank with host register port.
// Assumes a synchronous single-cycle register port from the host control
// logic on ref_clk, and sequencer enables from the same clock domain.
`timescale 1ns/1ns
module apo_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [apo_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [apo_pkg::DATA_W-1:0] reg_wdata,
  output logic [apo_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit,
  input wire logic [5:0] seq_left_a_on,
  input wire logic [7:0] seq_left_b_on,
  input wire logic [4:0] seq_right_on,
  output logic [5:0] left_a_pwr_on,
  output logic [7:0] left_b_pwr_on,
  output logic [4:0] right_pwr_on,
  output logic [7:0] right_force_en
);
  logic [7:0] ovr_a_q;
  logic [7:0] ovr_a_d;
  logic [7:0] ovr_b_q;
  logic [7:0] ovr_b_d;
  logic [7:0] state_a_q;
  logic [7:0] state_a_d;
  logic [7:0] state_b_q;
  logic [7:0] state_b_d;
  logic [7:0] r_ovr_q;
  logic [7:0] r_ovr_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic hit_q;
  logic hit_d;
  logic [7:0] rmux;
  logic sel_hit;
  logic [5:0] left_a_force;
  logic [5:0] left_a_state;
  logic [7:0] left_b_force;
  logic [7:0] left_b_state;
  logic [4:0] right_force;

  // Map and port shapes are byte wide throughout
  generate
    if (apo_pkg::ADDR_W != 8 || apo_pkg::DATA_W != 8)
    begin : g_bad_width
      $error("apo_regs: register port must be 8 bits wide");
    end
  endgenerate

  // Reserved bits are stored like any other, so all 8 bits are kept
  always_comb
  begin
    ovr_a_d = ovr_a_q;
    ovr_b_d = ovr_b_q;
    state_a_d = state_a_q;
    state_b_d = state_b_q;
    r_ovr_d = r_ovr_q;
    if (reg_wr)
    begin
      case (reg_addr)
        apo_pkg::OVR_A_ADDR: ovr_a_d = reg_wdata;
        apo_pkg::OVR_B_ADDR: ovr_b_d = reg_wdata;
        apo_pkg::STATE_A_ADDR: state_a_d = reg_wdata;
        apo_pkg::STATE_B_ADDR: state_b_d = reg_wdata;
        apo_pkg::R_OVR_A_ADDR: r_ovr_d = reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    sel_hit = 1'b1;
    case (reg_addr)
      apo_pkg::OVR_A_ADDR: rmux = ovr_a_q;
      apo_pkg::OVR_B_ADDR: rmux = ovr_b_q;
      apo_pkg::STATE_A_ADDR: rmux = state_a_q;
      apo_pkg::STATE_B_ADDR: rmux = state_b_q;
      apo_pkg::R_OVR_A_ADDR: rmux = r_ovr_q;
      default:
      begin
        // Foreign addresses belong to other banks; answer zero, flag miss
        rmux = 8'h00;
        sel_hit = 1'b0;
      end
    endcase
    rvalid_d = reg_rd;
    rdata_d = reg_rd ? rmux : rdata_q;
    hit_d = (reg_rd || reg_wr) ? sel_hit : hit_q;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ovr_a_q <= apo_pkg::OVR_A_RST;
      ovr_b_q <= apo_pkg::OVR_B_RST;
      state_a_q <= apo_pkg::STATE_A_RST;
      state_b_q <= apo_pkg::STATE_B_RST;
      r_ovr_q <= apo_pkg::R_OVR_A_RST;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      hit_q <= 1'b0;
    end
    else
    begin
      ovr_a_q <= ovr_a_d;
      ovr_b_q <= ovr_b_d;
      state_a_q <= state_a_d;
      state_b_q <= state_b_d;
      r_ovr_q <= r_ovr_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      hit_q <= hit_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign reg_hit = hit_q;
  assign right_force_en = r_ovr_q;

  // Fields picked by map position, so reserved bits never reach the muxes here;
  // right_force_en still carries bits 7:5 of the right override as written
  always_comb
  begin
    left_a_force = 6'h00;
    left_a_state = 6'h00;
    left_b_force = 8'h00;
    left_b_state = 8'h00;
    right_force = 5'h00;
    left_a_force[apo_pkg::A_BIAS_REF_BIT] = ovr_a_q[apo_pkg::A_BIAS_REF_BIT];
    left_a_force[apo_pkg::A_DAC_BIT] = ovr_a_q[apo_pkg::A_DAC_BIT];
    left_a_force[apo_pkg::A_DRIVER_BIT] = ovr_a_q[apo_pkg::A_DRIVER_BIT];
    left_a_force[apo_pkg::A_DRIVER_BIAS_BIT] = ovr_a_q[apo_pkg::A_DRIVER_BIAS_BIT];
    left_a_force[apo_pkg::A_CMFB_BIT] = ovr_a_q[apo_pkg::A_CMFB_BIT];
    left_a_force[apo_pkg::A_OUTSTAGE_BIT] = ovr_a_q[apo_pkg::A_OUTSTAGE_BIT];
    left_a_state[apo_pkg::A_BIAS_REF_BIT] = state_a_q[apo_pkg::A_BIAS_REF_BIT];
    left_a_state[apo_pkg::A_DAC_BIT] = state_a_q[apo_pkg::A_DAC_BIT];
    left_a_state[apo_pkg::A_DRIVER_BIT] = state_a_q[apo_pkg::A_DRIVER_BIT];
    left_a_state[apo_pkg::A_DRIVER_BIAS_BIT] = state_a_q[apo_pkg::A_DRIVER_BIAS_BIT];
    left_a_state[apo_pkg::A_CMFB_BIT] = state_a_q[apo_pkg::A_CMFB_BIT];
    left_a_state[apo_pkg::A_OUTSTAGE_BIT] = state_a_q[apo_pkg::A_OUTSTAGE_BIT];
    left_b_force[apo_pkg::B_GAINCTL_BIT] = ovr_b_q[apo_pkg::B_GAINCTL_BIT];
    left_b_force[apo_pkg::B_ANALOG_SILENCE_BIT] = ovr_b_q[apo_pkg::B_ANALOG_SILENCE_BIT];
    left_b_force[apo_pkg::B_ANALOG_SILENCE_DUMMY_BIT] = ovr_b_q[apo_pkg::B_ANALOG_SILENCE_DUMMY_BIT];
    left_b_force[apo_pkg::B_CHARGE_PUMP_BIT] = ovr_b_q[apo_pkg::B_CHARGE_PUMP_BIT];
    left_b_force[apo_pkg::B_OFFCAL_BIT] = ovr_b_q[apo_pkg::B_OFFCAL_BIT];
    left_b_force[apo_pkg::B_SHORTPROT_BIT] = ovr_b_q[apo_pkg::B_SHORTPROT_BIT];
    left_b_force[apo_pkg::B_IMPSENSE_BIT] = ovr_b_q[apo_pkg::B_IMPSENSE_BIT];
    left_b_force[apo_pkg::B_IMPWHOLE_BIT] = ovr_b_q[apo_pkg::B_IMPWHOLE_BIT];
    left_b_state[apo_pkg::B_GAINCTL_BIT] = state_b_q[apo_pkg::B_GAINCTL_BIT];
    left_b_state[apo_pkg::B_ANALOG_SILENCE_BIT] = state_b_q[apo_pkg::B_ANALOG_SILENCE_BIT];
    left_b_state[apo_pkg::B_ANALOG_SILENCE_DUMMY_BIT] = state_b_q[apo_pkg::B_ANALOG_SILENCE_DUMMY_BIT];
    left_b_state[apo_pkg::B_CHARGE_PUMP_BIT] = state_b_q[apo_pkg::B_CHARGE_PUMP_BIT];
    left_b_state[apo_pkg::B_OFFCAL_BIT] = state_b_q[apo_pkg::B_OFFCAL_BIT];
    left_b_state[apo_pkg::B_SHORTPROT_BIT] = state_b_q[apo_pkg::B_SHORTPROT_BIT];
    left_b_state[apo_pkg::B_IMPSENSE_BIT] = state_b_q[apo_pkg::B_IMPSENSE_BIT];
    left_b_state[apo_pkg::B_IMPWHOLE_BIT] = state_b_q[apo_pkg::B_IMPWHOLE_BIT];
    // Right fields sit at the group A positions below the bias reference
    right_force[apo_pkg::A_DAC_BIT] = r_ovr_q[apo_pkg::A_DAC_BIT];
    right_force[apo_pkg::A_DRIVER_BIT] = r_ovr_q[apo_pkg::A_DRIVER_BIT];
    right_force[apo_pkg::A_DRIVER_BIAS_BIT] = r_ovr_q[apo_pkg::A_DRIVER_BIAS_BIT];
    right_force[apo_pkg::A_CMFB_BIT] = r_ovr_q[apo_pkg::A_CMFB_BIT];
    right_force[apo_pkg::A_OUTSTAGE_BIT] = r_ovr_q[apo_pkg::A_OUTSTAGE_BIT];
  end

  // Left group A: bias ref, dac, driver, driver bias, cmfb, output stage
  apo_pwr_mux #(
    .WIDTH(6)
  ) u_left_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .force_en(left_a_force),
    .forced_on(left_a_state),
    .seq_on(seq_left_a_on),
    .pwr_on(left_a_pwr_on)
  );

  // Left group B: gain, mute, mute dummy, charge pump, offcal, short, imp, whole
  apo_pwr_mux #(
    .WIDTH(8)
  ) u_left_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .force_en(left_b_force),
    .forced_on(left_b_state),
    .seq_on(seq_left_b_on),
    .pwr_on(left_b_pwr_on)
  );

  // Right state registers live outside this bank; sequencer stands in
  // for the forced state so an override holds the sequencer level.
  apo_pwr_mux #(
    .WIDTH(5)
  ) u_right (
    .ref_clk(ref_clk),
    .rst(rst),
    .force_en(right_force),
    .forced_on(seq_right_on),
    .seq_on(seq_right_on),
    .pwr_on(right_pwr_on)
  );
endmodule

// >>> tb/apo_regs_properties.sv
// Concurrent checks on the override bank host port and power outputs.
// Assumes one ref_clk domain and the port set of apo_regs.
`timescale 1ns/1ns
module apo_regs_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit,
  input wire logic [5:0] seq_left_a_on,
  input wire logic [7:0] seq_left_b_on,
  input wire logic [4:0] seq_right_on,
  input wire logic [5:0] left_a_pwr_on,
  input wire logic [7:0] left_b_pwr_on,
  input wire logic [4:0] right_pwr_on,
  input wire logic [7:0] right_force_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic mapped = reg_addr inside {[8'h22:8'h26]};
  sequence s_wr_then_rd;
    reg_wr && mapped ##1 reg_rd && !reg_wr && reg_addr == $past(reg_addr);
  endsequence
  sequence s_clear(logic [7:0] a);
    reg_wr && reg_addr == a && reg_wdata == 8'h00 ##1 !reg_wr;
  endsequence
  property p_rvalid; reg_rd |=> reg_rvalid; endproperty
  property p_norvalid; !reg_rd |=> !reg_rvalid; endproperty
  property p_unmapped; reg_rd && !mapped |=> reg_rdata == 8'h00 && !reg_hit; endproperty
  property p_hit; reg_rd && mapped |=> reg_hit; endproperty
  property p_rback; s_wr_then_rd |=> reg_rdata == $past(reg_wdata, 2); endproperty
  property p_rfe; reg_wr && reg_addr == 8'h26 |=> right_force_en == $past(reg_wdata); endproperty
  property p_right; !$past(rst) |-> right_pwr_on == $past(seq_right_on); endproperty
  property p_seq_a; s_clear(8'h22) |=> left_a_pwr_on == $past(seq_left_a_on); endproperty
  property p_seq_b; s_clear(8'h23) |=> left_b_pwr_on == $past(seq_left_b_on); endproperty
  property p_wr_hit; reg_wr && mapped |=> reg_hit; endproperty
  property p_miss; (reg_wr || reg_rd) && !mapped |=> !reg_hit; endproperty
  property p_rdata_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  property p_hit_hold; !reg_rd && !reg_wr |=> $stable(reg_hit); endproperty
  a_rvalid: assert property (p_rvalid) else $error("no read answer");
  a_norvalid: assert property (p_norvalid) else $error("stray read answer");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  a_hit: assert property (p_hit) else $error("hit missing");
  a_rback: assert property (p_rback) else $error("readback differs");
  a_rfe: assert property (p_rfe) else $error("right override wrong");
  a_right: assert property (p_right) else $error("right power wrong");
  a_seq_a: assert property (p_seq_a) else $error("group a not sequenced");
  a_seq_b: assert property (p_seq_b) else $error("group b not sequenced");
  a_wr_hit: assert property (p_wr_hit) else $error("write hit missing");
  a_miss: assert property (p_miss) else $error("miss not flagged");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_hit_hold: assert property (p_hit_hold) else $error("hit flag moved");
endmodule

// >>> tb/apo_regs_tb.sv
// Self-checking bench for the analog power override register bank.
// Assumes apo_regs and its checker are compiled before this file.
`timescale 1ns/1ns
module apo_regs_tb;
  logic ref_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, seq_left_b_on = 8'h00;
  logic [5:0] seq_left_a_on = 6'h00, left_a_pwr_on;
  logic [4:0] seq_right_on = 5'h00, right_pwr_on;
  logic [7:0] reg_rdata, right_force_en, left_b_pwr_on;
  logic reg_rvalid, reg_hit;
  logic [7:0] m [8'h22:8'h26];
  int fails = 0, n_compared = 0;
  apo_regs uut (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .reg_hit(reg_hit),
    .seq_left_a_on(seq_left_a_on),
    .seq_left_b_on(seq_left_b_on),
    .seq_right_on(seq_right_on),
    .left_a_pwr_on(left_a_pwr_on),
    .left_b_pwr_on(left_b_pwr_on),
    .right_pwr_on(right_pwr_on),
    .right_force_en(right_force_en)
  );
  initial forever #2 ref_clk = ~ref_clk;
  function automatic logic [7:0] fx(logic [7:0] o, s, q);
    return (o & s) | (~o & q);
  endfunction
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    n_compared++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Strobes stay up after the edge; the next task sets what follows
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_rd = 1'h0;
    reg_wr = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1;
    if (a inside {[8'h22:8'h26]})
      m[a] = d;
  endtask
  task automatic rd(logic [7:0] a);
    logic h;
    h = a inside {[8'h22:8'h26]};
    reg_wr = 1'h0;
    reg_rd = 1'h1;
    reg_addr = a;
    @(posedge ref_clk);
    #1;
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    chk("hit", {7'h00, h}, {7'h00, reg_hit});
    chk("rdata", h ? m[a] : 8'h00, reg_rdata);
  endtask
  // Settles both flop stages of the power path before looking
  task automatic pw();
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("left_a", fx(m[8'h22] & 8'h3f, m[8'h24], {2'h0, seq_left_a_on}),
      {2'h0, left_a_pwr_on});
    chk("left_b", fx(m[8'h23], m[8'h25], seq_left_b_on), left_b_pwr_on);
    chk("right", {3'h0, seq_right_on}, {3'h0, right_pwr_on});
    chk("rfe", m[8'h26], right_force_en);
  endtask
  task automatic rd_all();
    foreach (m[a]) rd(8'(a));
  endtask
  initial
  begin
    void'($urandom(64));
    foreach (m[a]) m[a] = 8'h00;
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'h0;
    rd_all();
    rd(8'h27);
    rd(8'h21);
    $display("reset values done");
    foreach (m[a])
      for (int b = 0; b < 8; b++)
      begin
        wr(8'(a), 8'h01 << b);
        rd(8'(a));
      end
    $display("walking ones done");
    foreach (m[a])
    begin
      wr(8'(a), 8'h00);
      pw();
      wr(8'(a), 8'hff);
      pw();
    end
    repeat (40)
    begin
      seq_left_a_on = 6'($urandom);
      seq_left_b_on = 8'($urandom);
      seq_right_on = 5'($urandom);
      foreach (m[a]) wr(8'(a), 8'($urandom));
      pw();
    end
    $display("power select done");
    wr(8'h27, 8'hff);
    wr(8'h00, 8'hff);
    rd_all();
    $display("unmapped write done");
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    rst = 1'h1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("rst_a", 8'h00, {2'h0, left_a_pwr_on});
    chk("rst_b", 8'h00, left_b_pwr_on);
    chk("rst_right", 8'h00, {3'h0, right_pwr_on});
    chk("rst_rfe", 8'h00, right_force_en);
    chk("rst_rdata", 8'h00, reg_rdata);
    chk("rst_flags", 8'h00, {6'h00, reg_rvalid, reg_hit});
    foreach (m[a]) m[a] = 8'h00;
    rst = 1'h0;
    rd_all();
    $display("mid-run reset done");
    final_report();
  end
  // Whole run needs about 430 cycles; the watchdog fires at 25000
  initial
  begin
    #100000;
    fails++;
    final_report();
  end
endmodule
bind apo_regs apo_regs_properties chk_i (
  .ref_clk(ref_clk),
  .rst(rst),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .reg_hit(reg_hit),
  .seq_left_a_on(seq_left_a_on),
  .seq_left_b_on(seq_left_b_on),
  .seq_right_on(seq_right_on),
  .left_a_pwr_on(left_a_pwr_on),
  .left_b_pwr_on(left_b_pwr_on),
  .right_pwr_on(right_pwr_on),
  .right_force_en(right_force_en)
);
